//--- design/asisel_pkg.sv
// ****************************************************************
// analog setpoint input select: shared constants
// ****************************************************************
package asisel_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] OFF_VRANGE = 8'h00;
  localparam logic [7:0] OFF_SRANGE = 8'h04;
  localparam logic [7:0] OFF_EXTSEL = 8'h08;
  localparam logic [7:0] OFF_THERM = 8'h0c;
  localparam logic [7:0] OFF_VGAINF = 8'h10;
  localparam logic [7:0] OFF_SGAINF = 8'h14;
  localparam logic [7:0] OFF_VBIASF = 8'h18;
  localparam logic [7:0] OFF_VBIASP = 8'h1c;
  localparam logic [7:0] OFF_VGAINP = 8'h20;
  localparam logic [7:0] OFF_SGAINP = 8'h24;
  localparam logic [7:0] OFF_FILT = 8'h28;
  localparam logic [7:0] OFF_STATUS = 8'h2c;
  localparam logic [7:0] OFF_ASSIGN0 = 8'h30;
  // reset values
  localparam logic [3:0] RST_VRANGE = 4'h1;
  localparam logic [1:0] RST_SRANGE = 2'h0;
  localparam logic [15:0] RST_EXTSEL = 16'h0000;
  localparam logic [13:0] RST_THERM = 14'h270f;
  localparam logic [15:0] RST_GAINF = 16'h1388;
  localparam logic [15:0] RST_BIASF = 16'h0000;
  localparam logic [8:0] RST_VBIASP = 9'h000;
  localparam logic [8:0] RST_GAINP = 9'h064;
  localparam logic [3:0] RST_FILT = 4'h1;
  localparam logic [7:0] RST_ASSIGN = 8'h00;
  // encodings of the range selections
  localparam logic [3:0] VR_10V = 4'h0;
  localparam logic [3:0] VR_5V = 4'h1;
  localparam logic [3:0] VR_10V_REV = 4'ha;
  localparam logic [3:0] VR_5V_REV = 4'hb;
  localparam logic [1:0] SR_CUR = 2'h0;
  localparam logic [1:0] SR_5V = 2'h1;
  localparam logic [1:0] SR_10V = 2'h2;
  // misc values
  localparam logic [7:0] FUNC_TERM_SEL = 8'h04;
  localparam logic [13:0] THERM_OFF = 14'h270f;
  localparam logic [15:0] EXTSEL_OPEN = 16'h0000;
  localparam logic [8:0] SBIAS_POINT = 9'h014;
  localparam logic [15:0] SBIAS_FREQ = 16'h0000;
  localparam logic [3:0] FILT_MAX = 4'h8;
  localparam int PCT_PER_POINT = 10;
  // status word fields
  localparam int ST_DIR = 18;
  localparam int ST_SEC = 19;
  localparam int ST_IGN = 20;
endpackage

//--- design/asisel_lpf.sv
`timescale 1ns/1ps
// ****************************************************************
// first-order delay filter, one step per sample
// ****************************************************************
module asisel_lpf #(
  parameter int W = 12,
  parameter int SHW = 4,
  parameter int FRAC = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic [W-1:0] x,
  input wire logic [SHW-1:0] shift,
  output logic [W-1:0] y
);
  logic signed [W+FRAC:0] acc_r;
  logic signed [W+FRAC:0] err;

  // error kept signed so the step can go both ways
  assign err = $signed({1'b0, x, FRAC'(0)}) - acc_r;

  // larger shift gives a longer time constant, slower response
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc_r <= '0;
    end else if (en) begin
      acc_r <= acc_r + (err >>> shift);
    end
  end

  assign y = acc_r[W+FRAC-1:FRAC];
endmodule // asisel_lpf

//--- design/asisel_top.sv
// Decided for this implementation: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module asisel_top #(
  parameter int ADC_W = 12,
  parameter int NUM_DIN = 5
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic SAMPLE_VALID,
  input wire logic [ADC_W-1:0] VOLT_SAMPLE,
  input wire logic [ADC_W-1:0] SECOND_SAMPLE,
  input wire logic SWITCH_V,
  input wire logic [NUM_DIN-1:0] DIN,
  output logic signed [17:0] FREQ_CMD,
  output logic DIR_REV,
  output logic CMD_VALID,
  output logic SECOND_SELECTED,
  output logic VOLT_IGNORED
);
  // ****************************************************************
  // bus slave
  // ****************************************************************
  logic accept;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic hready_r;
  logic [31:0] hrdata_r;
  logic wr_en;
  logic [31:0] rd_val;
  logic [3:0] vrange_r;
  logic [1:0] srange_r;
  logic [15:0] extsel_r;
  logic [13:0] therm_r;
  logic [15:0] vgainf_r, sgainf_r, vbiasf_r;
  logic [8:0] vbiasp_r, vgainp_r, sgainp_r;
  logic [3:0] filt_r;
  logic [7:0] assign_r [NUM_DIN];
  logic [NUM_DIN-1:0] din_hit;
  logic sec_sel;
  logic valid_d1_r;
  logic [ADC_W-1:0] vy, sy;
  logic signed [17:0] freq_r;
  logic dir_r, cmd_valid_r, sec_r, ign_r;

  assign accept = HSEL && HTRANS[1] && HREADY;

  // a write costs one wait state so a read straight after sees it
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hready_r <= 1'b1;
    end else if (accept && HWRITE) begin
      wr_pend_r <= 1'b1;
      wr_addr_r <= HADDR[7:0];
      hready_r <= 1'b0;
    end else begin
      wr_pend_r <= 1'b0;
      hready_r <= 1'b1;
    end
  end

  // parameters other than the selector itself are locked when it is set
  assign wr_en = wr_pend_r && (extsel_r == asisel_pkg::EXTSEL_OPEN ||
                 wr_addr_r == asisel_pkg::OFF_EXTSEL);

  // range registers; illegal codes are dropped, old value kept
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      vrange_r <= asisel_pkg::RST_VRANGE;
      srange_r <= asisel_pkg::RST_SRANGE;
    end else if (wr_en) begin
      // slope logic further down reads this code for reverse and 5V scaling
      if (wr_addr_r == asisel_pkg::OFF_VRANGE &&
          (HWDATA[31:0] == 32'(asisel_pkg::VR_10V) ||
           HWDATA[31:0] == 32'(asisel_pkg::VR_5V) ||
           HWDATA[31:0] == 32'(asisel_pkg::VR_10V_REV) ||
           HWDATA[31:0] == 32'(asisel_pkg::VR_5V_REV))) begin
        vrange_r <= HWDATA[3:0];
      end
      if (wr_addr_r == asisel_pkg::OFF_SRANGE &&
          HWDATA[31:0] <= 32'(asisel_pkg::SR_10V)) begin
        srange_r <= HWDATA[1:0];
      end
    end
  end

  // calibration, selector, thermistor and filter settings
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      extsel_r <= asisel_pkg::RST_EXTSEL;
      therm_r <= asisel_pkg::RST_THERM;
      vgainf_r <= asisel_pkg::RST_GAINF;
      sgainf_r <= asisel_pkg::RST_GAINF;
      vbiasf_r <= asisel_pkg::RST_BIASF;
      vbiasp_r <= asisel_pkg::RST_VBIASP;
      vgainp_r <= asisel_pkg::RST_GAINP;
      sgainp_r <= asisel_pkg::RST_GAINP;
      filt_r <= asisel_pkg::RST_FILT;
    end else if (wr_en) begin
      unique case (wr_addr_r)
        asisel_pkg::OFF_EXTSEL: extsel_r <= HWDATA[15:0];
        asisel_pkg::OFF_THERM: therm_r <= HWDATA[13:0];
        asisel_pkg::OFF_VGAINF: vgainf_r <= HWDATA[15:0];
        asisel_pkg::OFF_SGAINF: sgainf_r <= HWDATA[15:0];
        asisel_pkg::OFF_VBIASF: vbiasf_r <= HWDATA[15:0];
        asisel_pkg::OFF_VBIASP: vbiasp_r <= HWDATA[8:0];
        asisel_pkg::OFF_VGAINP: vgainp_r <= HWDATA[8:0];
        asisel_pkg::OFF_SGAINP: sgainp_r <= HWDATA[8:0];
        asisel_pkg::OFF_FILT: begin
          if (HWDATA[31:0] <= 32'(asisel_pkg::FILT_MAX)) begin
            filt_r <= HWDATA[3:0];
          end
        end
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // input function assignment per digital terminal
  // ****************************************************************
  generate
    for (genvar i = 0; i < NUM_DIN; i++) begin : g_din
      localparam logic [7:0] OFF_I = 8'(asisel_pkg::OFF_ASSIGN0 + 4 * i);
      always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
          assign_r[i] <= asisel_pkg::RST_ASSIGN;
        end else if (wr_en && wr_addr_r == OFF_I) begin
          assign_r[i] <= HWDATA[7:0];
        end
      end
      // terminal drives the select only when given code 4
      assign din_hit[i] = DIN[i] &&
        assign_r[i] == asisel_pkg::FUNC_TERM_SEL;
    end
  endgenerate

  assign sec_sel = |din_hit;

  // read mux; unmapped offsets read zero
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (HADDR[7:0])
      asisel_pkg::OFF_VRANGE: rd_val = 32'(vrange_r);
      asisel_pkg::OFF_SRANGE: rd_val = 32'(srange_r);
      asisel_pkg::OFF_EXTSEL: rd_val = 32'(extsel_r);
      asisel_pkg::OFF_THERM: rd_val = 32'(therm_r);
      asisel_pkg::OFF_VGAINF: rd_val = 32'(vgainf_r);
      asisel_pkg::OFF_SGAINF: rd_val = 32'(sgainf_r);
      asisel_pkg::OFF_VBIASF: rd_val = 32'(vbiasf_r);
      asisel_pkg::OFF_VBIASP: rd_val = 32'(vbiasp_r);
      asisel_pkg::OFF_VGAINP: rd_val = 32'(vgainp_r);
      asisel_pkg::OFF_SGAINP: rd_val = 32'(sgainp_r);
      asisel_pkg::OFF_FILT: rd_val = 32'(filt_r);
      asisel_pkg::OFF_STATUS: begin
        rd_val[17:0] = freq_r;
        rd_val[asisel_pkg::ST_DIR] = dir_r;
        rd_val[asisel_pkg::ST_SEC] = sec_r;
        rd_val[asisel_pkg::ST_IGN] = ign_r;
      end
      default: begin
        for (int k = 0; k < NUM_DIN; k++) begin
          if (HADDR[7:0] == 8'(asisel_pkg::OFF_ASSIGN0 + 4 * k)) begin
            rd_val = 32'(assign_r[k]);
          end
        end
      end
    endcase
  end

  // read data captured in the address phase, zero wait
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      hrdata_r <= 32'h0000_0000;
    end else if (accept && !HWRITE) begin
      hrdata_r <= rd_val;
    end
  end

  assign HRDATA = hrdata_r;
  assign HREADYOUT = hready_r;
  assign HRESP = 1'b0;

  // ****************************************************************
  // filtering and range interpretation
  // ****************************************************************
  asisel_lpf #(.W(ADC_W), .SHW(4), .FRAC(8)) u_vfilt (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .en(SAMPLE_VALID),
    .x(VOLT_SAMPLE),
    .shift(filt_r),
    .y(vy)
  );

  asisel_lpf #(.W(ADC_W), .SHW(4), .FRAC(8)) u_sfilt (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .en(SAMPLE_VALID),
    .x(SECOND_SAMPLE),
    .shift(filt_r),
    .y(sy)
  );

  logic rev, v_half, s_volt_half;
  logic [12:0] v_pct, s_pct, pct;
  logic [15:0] bf, gf;
  logic [8:0] bp, gp;
  int dx, span, f;
  logic ign;

  assign rev = vrange_r == asisel_pkg::VR_10V_REV ||
               vrange_r == asisel_pkg::VR_5V_REV;
  assign v_half = vrange_r == asisel_pkg::VR_5V ||
                  vrange_r == asisel_pkg::VR_5V_REV;
  // 5V input only when code and switch agree; else current scaling
  assign s_volt_half = srange_r == asisel_pkg::SR_5V && SWITCH_V;
  // converter code 4000 is 10V or 20mA; pct in tenths of a percent
  assign v_pct = v_half ? 13'(vy[ADC_W-1:1]) : 13'(vy[ADC_W-1:2]);
  assign s_pct = s_volt_half ? 13'(sy[ADC_W-1:1]) :
                 13'(sy[ADC_W-1:2]);
  assign ign = !sec_sel && therm_r != asisel_pkg::THERM_OFF;

  // pick the calibration of the terminal in use
  always_comb begin
    if (sec_sel) begin
      pct = s_pct;
      bf = asisel_pkg::SBIAS_FREQ;
      gf = sgainf_r;
      bp = asisel_pkg::SBIAS_POINT; // 4mA is the default bias
      gp = sgainp_r;
    end else begin
      pct = v_pct;
      bf = vbiasf_r;
      gf = vgainf_r;
      bp = vbiasp_r;
      gp = vgainp_r;
    end
  end

  // straight line through bias and gain points, clamped at both ends
  always_comb begin
    dx = int'(pct) - int'(bp) * asisel_pkg::PCT_PER_POINT;
    span = (int'(gp) - int'(bp)) * asisel_pkg::PCT_PER_POINT;
    if (ign) begin
      f = 0;
    end else if (span <= 0) begin
      f = int'(gf); // degenerate calibration, hold the gain
    end else if (dx >= span) begin
      f = int'(gf);
    end else if (!rev && dx <= 0) begin
      f = int'(bf);
    end else begin
      // below bias this goes negative: reverse rotation
      f = int'(bf) + dx * (int'(gf) - int'(bf)) / span;
    end
    if (rev && f < -int'(gf)) begin
      f = -int'(gf);
    end
  end

  // ****************************************************************
  // command output, one result per converter sample
  // ****************************************************************
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      valid_d1_r <= 1'b0;
      cmd_valid_r <= 1'b0;
    end else begin
      valid_d1_r <= SAMPLE_VALID;
      cmd_valid_r <= valid_d1_r;
    end
  end

  // outputs hold between samples, so direction stays from the last
  // filtered reading even when the source goes quiet
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      freq_r <= 18'h00000;
      dir_r <= 1'b0;
      sec_r <= 1'b0;
      ign_r <= 1'b0;
    end else if (valid_d1_r) begin
      freq_r <= 18'(f);
      dir_r <= f < 0;
      sec_r <= sec_sel;
      ign_r <= ign;
    end
  end

  assign FREQ_CMD = freq_r;
  assign DIR_REV = dir_r;
  assign CMD_VALID = cmd_valid_r;
  assign SECOND_SELECTED = sec_r;
  assign VOLT_IGNORED = ign_r;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  sequence s_wr_addr;
    accept && HWRITE;
  endsequence

  sequence s_wait_one;
    !HREADYOUT ##1 HREADYOUT;
  endsequence

  a_write_wait_state: assert property (
    s_wr_addr |=> s_wait_one)
    else $error("write did not take exactly one wait state");

  a_range_lock: assert property (
    wr_pend_r && extsel_r != asisel_pkg::EXTSEL_OPEN &&
    wr_addr_r == asisel_pkg::OFF_VRANGE |=> $stable(vrange_r))
    else $error("range code changed while selector locked");

  a_range_reset: assert property (
    $rose(RST_N) |-> vrange_r == asisel_pkg::RST_VRANGE &&
    srange_r == asisel_pkg::RST_SRANGE)
    else $error("range codes wrong after reset");

  a_cmd_latency: assert property (
    SAMPLE_VALID |-> ##2 CMD_VALID)
    else $error("command not valid two cycles after sample");

  a_volt_ignored: assert property (
    valid_d1_r && !sec_sel && therm_r != asisel_pkg::THERM_OFF
    |=> VOLT_IGNORED && FREQ_CMD == 18'h00000)
    else $error("voltage terminal used with thermistor active");

  a_din_select: assert property (
    valid_d1_r && DIN[0] && assign_r[0] == asisel_pkg::FUNC_TERM_SEL
    |=> SECOND_SELECTED)
    else $error("assigned input did not select second terminal");

  a_no_reverse: assert property (
    CMD_VALID && !rev && $stable(vrange_r) |-> !DIR_REV)
    else $error("reverse rotation outside reversible mode");

  a_dir_sign: assert property (
    CMD_VALID |-> DIR_REV == (FREQ_CMD < 0))
    else $error("direction disagrees with command sign");

  // an inverse line may put the bias frequency above the gain
  a_gain_clamp: assert property (
    valid_d1_r && !sec_sel && !ign |=>
    FREQ_CMD <= $signed({2'b00, $past(vgainf_r)}) ||
    FREQ_CMD <= $signed({2'b00, $past(vbiasf_r)}))
    else $error("command above gain and bias frequency");
endmodule // asisel_top

//--- verification/asisel_src_model.sv
`timescale 1ns/1ps
// ****************************************************************
// converter model: hands both terminal codes over in one cycle
// ****************************************************************
module asisel_src_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [11:0] volt_in,
  input wire logic [11:0] second_in,
  output logic sample_valid,
  output logic [11:0] volt_code,
  output logic [11:0] second_code
);
  initial begin
    sample_valid = 1'b0;
    volt_code = 12'h000;
    second_code = 12'h000;
  end

  // codes toggle between samples so stale reads give garbage, not a match
  always @(posedge clk) begin
    sample_valid <= go;
    if (go) begin
      volt_code <= volt_in;
      second_code <= second_in;
    end else begin
      volt_code <= ~volt_code;
      second_code <= ~second_code;
    end
  end
endmodule // asisel_src_model

//--- verification/tb_top.sv
`timescale 1ns/1ps
// ****************************************************************
// bench for the analog setpoint input select block
// ****************************************************************
module tb_top;
  logic clk, rst_n, hsel, hwrite, hready, hreadyout, hresp, go, sw_v;
  logic smp_v, cmd_v, dir_rev, sec_sel, v_ign;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic [11:0] vin, sin, v_code, s_code;
  logic [4:0] din;
  logic signed [17:0] freq;
  int n_errors, n_compared;

  assign hready = hreadyout; // one slave, so its ready is the bus ready

  asisel_top dut (
    .CORE_CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hreadyout),
    .HRESP(hresp), .SAMPLE_VALID(smp_v), .VOLT_SAMPLE(v_code),
    .SECOND_SAMPLE(s_code), .SWITCH_V(sw_v), .DIN(din), .FREQ_CMD(freq),
    .DIR_REV(dir_rev), .CMD_VALID(cmd_v), .SECOND_SELECTED(sec_sel),
    .VOLT_IGNORED(v_ign)
  );

  asisel_src_model src (
    .clk(clk), .go(go), .volt_in(vin), .second_in(sin),
    .sample_valid(smp_v), .volt_code(v_code), .second_code(s_code)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one single transfer; each wait is bounded and a stall ends the run
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int k;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    k = 0;
    do begin @(posedge clk); k++; end while (hready !== 1'b1 && k < 20);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge clk); k++; end while (hready !== 1'b1 && k < 20);
    q = hrdata;
    chk("okay", {31'h0, hresp}, 32'h0);
    if (k >= 20) begin
      n_errors++;
      $display("unexpected hready expected 1 seen 0");
      tally_and_finish();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk($sformatf("reg %h", a), q, e);
  endtask

  // result lands one edge after the sample edge and stands one cycle;
  // it is read at the next edge, before that edge moves the flops
  task automatic smp(input logic [11:0] v, s, input int ef,
                     input logic ed, es, ei);
    go <= 1'b1;
    vin <= v;
    sin <= s;
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
    chk("valid", {31'h0, cmd_v}, 32'h1);
    chk("freq", {14'h0, freq}, {14'h0, 18'(ef)});
    chk("dir", {31'h0, dir_rev}, {31'h0, ed});
    chk("second", {31'h0, sec_sel}, {31'h0, es});
    chk("ignored", {31'h0, v_ign}, {31'h0, ei});
    @(posedge clk);
    chk("pulse", {31'h0, cmd_v}, 32'h0);
  endtask

  task automatic sc_reset();
    chk("freq", {14'h0, freq}, 32'h0);
    rd(asisel_pkg::OFF_VRANGE, 32'h1);
    rd(asisel_pkg::OFF_SRANGE, 32'h0);
    rd(asisel_pkg::OFF_THERM, 32'h270f);
    rd(asisel_pkg::OFF_FILT, 32'h1);
    rd(8'h80, 32'h0);
  endtask

  task automatic sc_filter();
    smp(12'd2000, 12'd0, 2500, 1'b0, 1'b0, 1'b0);
    smp(12'd2000, 12'd0, 3750, 1'b0, 1'b0, 1'b0);
    wr(asisel_pkg::OFF_FILT, 32'h9);
    rd(asisel_pkg::OFF_FILT, 32'h1);
    wr(asisel_pkg::OFF_FILT, 32'h0);
    smp(12'd2000, 12'd0, 5000, 1'b0, 1'b0, 1'b0);
    smp(12'd1000, 12'd0, 2500, 1'b0, 1'b0, 1'b0);
  endtask

  task automatic sc_range10();
    wr(asisel_pkg::OFF_VRANGE, 32'h0);
    smp(12'd4000, 12'd0, 5000, 1'b0, 1'b0, 1'b0);
    smp(12'd2000, 12'd0, 2500, 1'b0, 1'b0, 1'b0);
    wr(asisel_pkg::OFF_VRANGE, 32'h5);
    rd(asisel_pkg::OFF_VRANGE, 32'h0);
  endtask

  task automatic sc_gate();
    wr(asisel_pkg::OFF_EXTSEL, 32'h1);
    wr(asisel_pkg::OFF_VRANGE, 32'h1);
    rd(asisel_pkg::OFF_VRANGE, 32'h0);
    wr(asisel_pkg::OFF_EXTSEL, 32'h0);
    wr(asisel_pkg::OFF_VRANGE, 32'h1);
    rd(asisel_pkg::OFF_VRANGE, 32'h1);
  endtask

  task automatic sc_clamp();
    wr(asisel_pkg::OFF_VBIASF, 32'd1000);
    wr(asisel_pkg::OFF_VBIASP, 32'd20);
    wr(asisel_pkg::OFF_VGAINP, 32'd80);
    smp(12'd200, 12'd0, 1000, 1'b0, 1'b0, 1'b0);
    smp(12'd2000, 12'd0, 5000, 1'b0, 1'b0, 1'b0);
    smp(12'd1000, 12'd0, 3000, 1'b0, 1'b0, 1'b0);
    wr(asisel_pkg::OFF_VBIASF, 32'd0);
    wr(asisel_pkg::OFF_VBIASP, 32'd0);
    wr(asisel_pkg::OFF_VGAINP, 32'd100);
  endtask

  // bias point at half the gain point splits the span at 2.5V
  task automatic sc_reverse();
    wr(asisel_pkg::OFF_VRANGE, 32'd11);
    wr(asisel_pkg::OFF_VBIASP, 32'd50);
    smp(12'd0, 12'd0, -5000, 1'b1, 1'b0, 1'b0);
    smp(12'd400, 12'd0, -3000, 1'b1, 1'b0, 1'b0);
    rd(asisel_pkg::OFF_STATUS, {14'h1, 18'(-3000)});
    smp(12'd1000, 12'd0, 0, 1'b0, 1'b0, 1'b0);
    smp(12'd2000, 12'd0, 5000, 1'b0, 1'b0, 1'b0);
    wr(asisel_pkg::OFF_VBIASP, 32'd0);
  endtask

  task automatic sc_second();
    wr(asisel_pkg::OFF_ASSIGN0 + 8'h08, 32'h4);
    din <= 5'h04;
    smp(12'd0, 12'd400, -625, 1'b1, 1'b1, 1'b0);
    smp(12'd0, 12'd800, 0, 1'b0, 1'b1, 1'b0);
    smp(12'd0, 12'd4000, 5000, 1'b0, 1'b1, 1'b0);
    din <= 5'h01;
    smp(12'd1000, 12'd4000, 2500, 1'b0, 1'b0, 1'b0);
    wr(asisel_pkg::OFF_ASSIGN0, 32'h4);
    smp(12'd0, 12'd4000, 5000, 1'b0, 1'b1, 1'b0);
    wr(asisel_pkg::OFF_ASSIGN0, 32'h0);
    din <= 5'h04;
    wr(asisel_pkg::OFF_VRANGE, 32'h1);
    smp(12'd0, 12'd400, 0, 1'b0, 1'b1, 1'b0);
    wr(asisel_pkg::OFF_SRANGE, 32'h1);
    sw_v <= 1'b1;
    smp(12'd0, 12'd2000, 5000, 1'b0, 1'b1, 1'b0);
    sw_v <= 1'b0;
    smp(12'd0, 12'd2000, 1875, 1'b0, 1'b1, 1'b0);
    wr(asisel_pkg::OFF_SRANGE, 32'h2);
    sw_v <= 1'b1;
    smp(12'd0, 12'd2000, 1875, 1'b0, 1'b1, 1'b0);
    wr(asisel_pkg::OFF_SRANGE, 32'h3);
    rd(asisel_pkg::OFF_SRANGE, 32'h2);
    din <= 5'h00;
  endtask

  task automatic sc_therm();
    wr(asisel_pkg::OFF_THERM, 32'd100);
    smp(12'd2000, 12'd0, 0, 1'b0, 1'b0, 1'b1);
    wr(asisel_pkg::OFF_THERM, 32'h270f);
    smp(12'd2000, 12'd0, 5000, 1'b0, 1'b0, 1'b0);
  endtask

  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    go = 1'b0;
    vin = 12'h000;
    sin = 12'h000;
    sw_v = 1'b0;
    din = 5'h00;
    n_errors = 0;
    n_compared = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    sc_reset();
    sc_filter();
    sc_range10();
    sc_gate();
    sc_clamp();
    sc_reverse();
    sc_second();
    sc_therm();
    tally_and_finish();
  end
endmodule // tb_top
